// file: rtl/gpp_pkg.sv
package gpp_pkg;
    // ----------------------------------------
    // sizes
    // ----------------------------------------
    localparam int GPP_PINS = 40;
    localparam int GPP_PORTS = 5;
    localparam int GPP_CFG_W = 7;
    localparam int GPP_CTL_W = 10;
    localparam int GPP_SPI_N = 4;
    localparam int GPP_LOOSE_IRQ = 16;
    localparam int GPP_SHARED_IRQ = 3;
    localparam logic [39:0] GPP_VALID_MASK = 40'h0f_ffff_ffff;

    // ----------------------------------------
    // register indices, byte address is index times four
    // ----------------------------------------
    localparam logic [5:0] GPP_IDX_PORT [GPP_PORTS] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04};
    localparam logic [5:0] GPP_IDX_CFG0 = 6'h05;
    localparam logic [5:0] GPP_IDX_CTRL = 6'h30;

    // ----------------------------------------
    // per-pin configuration fields
    // ----------------------------------------
    localparam int GPP_CFG_OE = 0;
    localparam int GPP_CFG_PULLUP = 1;
    localparam int GPP_CFG_OD = 2;
    localparam int GPP_CFG_SINK = 3;
    localparam int GPP_CFG_TTL = 4;
    localparam int GPP_CFG_ACT_LOW = 5;
    localparam int GPP_CFG_INT_EN = 6;

    // ----------------------------------------
    // control register fields
    // ----------------------------------------
    localparam int GPP_CTL_XTAL = 0;
    localparam int GPP_CTL_REG_SEL = 1;
    localparam int GPP_CTL_REG_ON = 2;
    localparam int GPP_CTL_LOW_RAIL = 3;
    localparam int GPP_CTL_USB_MODE = 4;
    localparam int GPP_CTL_USB_FORCE = 5;
    localparam int GPP_CTL_SPI_USE = 6;

    // ----------------------------------------
    // shared-function pins
    // ----------------------------------------
    localparam int GPP_PIN_OSC_IN = 0;
    localparam int GPP_PIN_OSC_OUT = 1;
    localparam int GPP_PIN_USB_DP = 8;
    localparam int GPP_PIN_USB_DM = 9;
    localparam int GPP_PIN_REG = 10;
    localparam int GPP_PIN_SPI0 = 11;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [39:0] GPP_RST_DATA = 40'h00_0000_0000;
    localparam logic [6:0] GPP_RST_CFG = 7'h00;
    localparam logic [9:0] GPP_RST_CTRL = 10'h000;
endpackage : gpp_pkg

// file: rtl/gpp_sync.sv
`timescale 1ns/1ps
module gpp_sync #(
    parameter int W = 8
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    // ----------------------------------------
    // two-flop synchroniser
    // ----------------------------------------
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } gpp_sync_s;

    gpp_sync_s q;
    gpp_sync_s d;

    always_comb begin
        d.meta = i_d;
        d.sync = q.meta;
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_q = q.sync;
endmodule : gpp_sync

// file: rtl/gpp_gpio_port.sv
// Function
// RQ1: writes set levels of output-enabled pins
// RQ2: data reads return sampled pin levels
// RQ3: interrupts work for inputs and outputs
// RQ4: edge-triggered; shared groups rearm when idle
// RQ5: cleared enable never raises pin interrupt
// RQ6: driven data edge raises own interrupt
// RQ7: polarity set falling, cleared rising
// RQ8: threshold bit selects TTL or CMOS
// RQ9: sink bit selects high sink rating
// RQ10: open drain: one floats, zero drives low
// RQ11: push-pull drives both levels
// RQ12: pull-up bit connects pin pull-up
// RQ13: output enable turns driver on
// RQ14: oscillator pins undriven while crystal on
// RQ15: dedicated select disables GPIO enable
// RQ16: serial logic owns its pin enables
// RQ17: low rail drive on four serial pins
// RQ18: regulator select outputs regulator, no GPIO
// RQ19: USB mode hands pins to data lines
// RQ20: force bit drives USB lines from data
// RQ21: software disables interrupt before polarity change
// RQ22: reserved bits zero, everything resets zero; the code resets waitrequest (wreq) to one
`timescale 1ns/1ps
module gpp_gpio_port (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic [gpp_pkg::GPP_PINS-1:0] i_pin,
    output logic [gpp_pkg::GPP_PINS-1:0] o_pin_out,
    output logic [gpp_pkg::GPP_PINS-1:0] o_pin_oe,
    output logic [gpp_pkg::GPP_PINS-1:0] o_pin_ttl,
    output logic [gpp_pkg::GPP_PINS-1:0] o_pin_high_sink,
    output logic [gpp_pkg::GPP_PINS-1:0] o_pin_pullup,
    input wire logic [gpp_pkg::GPP_SPI_N-1:0] i_spi_oe,
    input wire logic [gpp_pkg::GPP_SPI_N-1:0] i_spi_out,
    input wire logic i_usb_oe,
    input wire logic [1:0] i_usb_out,
    output logic [gpp_pkg::GPP_SPI_N-1:0] o_low_rail_drive,
    output logic o_crystal_osc_on,
    output logic o_regulator_pin_drive,
    output logic o_regulator_on,
    output logic o_usb_mode,
    output logic [gpp_pkg::GPP_LOOSE_IRQ-1:0] o_pin_irq,
    output logic [gpp_pkg::GPP_SHARED_IRQ-1:0] o_shared_irq
);
    import gpp_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [GPP_PINS-1:0] dat;
        logic [GPP_PINS-1:0][GPP_CFG_W-1:0] cfg;
        logic [GPP_CTL_W-1:0] ctrl;
        logic [GPP_PINS-1:0] out;
        logic [GPP_PINS-1:0] oe;
        logic [GPP_PINS-1:0] hit;
        logic [GPP_LOOSE_IRQ-1:0] irq;
        logic [GPP_SHARED_IRQ-1:0] grp;
        logic [GPP_SHARED_IRQ-1:0] sirq;
        logic wreq;
        logic [31:0] rdata;
    } gpp_state_s;

    gpp_state_s q;
    gpp_state_s d;
    logic [GPP_PINS-1:0] pin_s;
    logic [GPP_PINS-1:0] pin_m;
    logic [5:0] idx;
    logic [31:0] rd_v;
    logic [GPP_PINS-1:0] hit_v;
    logic [GPP_SPI_N-1:0] spi_use;

    // ----------------------------------------
    // pin sampling
    // ----------------------------------------
    gpp_sync #(
        .W(GPP_PINS)
    ) u_sync (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_d(i_pin),
        .o_q(pin_s)
    );

    assign pin_m = pin_s & GPP_VALID_MASK;
    assign idx = i_avs_address[7:2];
    assign spi_use = q.ctrl[GPP_CTL_SPI_USE +: GPP_SPI_N];

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    always_comb begin
        rd_v = 32'h0000_0000;
        for (int k = 0; k < GPP_PORTS; k++) begin
            if (idx == GPP_IDX_PORT[k]) begin
                rd_v[7:0] = pin_m[k*8 +: 8]; // RQ2 RQ22
            end
        end
        for (int p = 0; p < GPP_PINS; p++) begin
            if (idx == 6'(GPP_IDX_CFG0 + 6'(p))) begin
                rd_v[GPP_CFG_W-1:0] = q.cfg[p];
            end
        end
        if (idx == GPP_IDX_CTRL) begin
            rd_v[GPP_CTL_W-1:0] = q.ctrl;
        end
    end

    // ----------------------------------------
    // interrupt levels
    // ----------------------------------------
    always_comb begin
        logic lvl;
        lvl = 1'b0;
        hit_v = '0;
        for (int p = 0; p < GPP_PINS; p++) begin
            lvl = q.oe[p] ? q.out[p] : pin_s[p]; // RQ3 RQ6
            hit_v[p] = (lvl ^ q.cfg[p][GPP_CFG_ACT_LOW]) & q.cfg[p][GPP_CFG_INT_EN] & GPP_VALID_MASK[p]; // RQ5 RQ7
        end
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        logic en_v;
        logic o_v;
        logic g_v;
        en_v = 1'b0;
        o_v = 1'b0;
        g_v = 1'b0;
        d = q;
        d.wreq = 1'b1;
        if ((i_avs_read || i_avs_write) && q.wreq) begin
            d.wreq = 1'b0;
            d.rdata = rd_v;
        end
        if (i_avs_write && !q.wreq && i_avs_byteenable[0]) begin
            for (int k = 0; k < GPP_PORTS; k++) begin
                if (idx == GPP_IDX_PORT[k]) begin
                    d.dat[k*8 +: 8] = i_avs_writedata[7:0] & GPP_VALID_MASK[k*8 +: 8]; // RQ1 RQ22
                end
            end
            for (int p = 0; p < GPP_PINS; p++) begin
                if (idx == 6'(GPP_IDX_CFG0 + 6'(p)) && GPP_VALID_MASK[p]) begin
                    d.cfg[p] = i_avs_writedata[GPP_CFG_W-1:0];
                end
            end
        end
        if (i_avs_write && !q.wreq && idx == GPP_IDX_CTRL && i_avs_byteenable[0] && i_avs_byteenable[1]) begin
            d.ctrl = i_avs_writedata[GPP_CTL_W-1:0];
        end
        for (int p = 0; p < GPP_PINS; p++) begin
            en_v = q.cfg[p][GPP_CFG_OE]; // RQ13
            o_v = q.dat[p]; // RQ1 RQ11
            if (q.cfg[p][GPP_CFG_OD]) begin
                en_v = en_v & ~q.dat[p]; // RQ10
                o_v = 1'b0;
            end
            if ((p == GPP_PIN_OSC_IN || p == GPP_PIN_OSC_OUT) && q.ctrl[GPP_CTL_XTAL]) begin
                en_v = 1'b0; // RQ14
            end
            if (p == GPP_PIN_REG && q.ctrl[GPP_CTL_REG_SEL]) begin
                en_v = 1'b0; // RQ15 RQ18
            end
            if (p >= GPP_PIN_SPI0 && p < GPP_PIN_SPI0 + GPP_SPI_N) begin
                if (spi_use[p-GPP_PIN_SPI0]) begin
                    en_v = i_spi_oe[p-GPP_PIN_SPI0]; // RQ15 RQ16
                    o_v = i_spi_out[p-GPP_PIN_SPI0];
                end
            end
            if ((p == GPP_PIN_USB_DP || p == GPP_PIN_USB_DM) && q.ctrl[GPP_CTL_USB_MODE]) begin
                if (q.ctrl[GPP_CTL_USB_FORCE]) begin
                    en_v = 1'b1; // RQ20
                    o_v = q.dat[p];
                end else begin
                    en_v = i_usb_oe; // RQ19
                    o_v = i_usb_out[p-GPP_PIN_USB_DP];
                end
            end
            d.oe[p] = en_v & GPP_VALID_MASK[p];
            d.out[p] = o_v & GPP_VALID_MASK[p];
        end
        d.hit = hit_v;
        d.irq = hit_v[GPP_LOOSE_IRQ-1:0] & ~q.hit[GPP_LOOSE_IRQ-1:0]; // RQ4
        for (int k = 0; k < GPP_SHARED_IRQ; k++) begin
            g_v = |hit_v[(k+2)*8 +: 8];
            d.grp[k] = g_v;
            d.sirq[k] = g_v & ~q.grp[k]; // RQ4
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            q <= '0; // RQ22
            q.dat <= GPP_RST_DATA;
            q.cfg <= {GPP_PINS{GPP_RST_CFG}};
            q.ctrl <= GPP_RST_CTRL;
            q.wreq <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    for (genvar g = 0; g < GPP_PINS; g++) begin : g_cfg_out
        assign o_pin_ttl[g] = q.cfg[g][GPP_CFG_TTL]; // RQ8
        assign o_pin_high_sink[g] = q.cfg[g][GPP_CFG_SINK]; // RQ9
        assign o_pin_pullup[g] = q.cfg[g][GPP_CFG_PULLUP]; // RQ12
    end

    assign o_avs_readdata = q.rdata;
    assign o_avs_waitrequest = q.wreq;
    assign o_pin_out = q.out;
    assign o_pin_oe = q.oe;
    assign o_low_rail_drive = {GPP_SPI_N{q.ctrl[GPP_CTL_LOW_RAIL]}}; // RQ17
    assign o_crystal_osc_on = q.ctrl[GPP_CTL_XTAL];
    assign o_regulator_pin_drive = q.ctrl[GPP_CTL_REG_SEL]; // RQ18
    assign o_regulator_on = q.ctrl[GPP_CTL_REG_ON];
    assign o_usb_mode = q.ctrl[GPP_CTL_USB_MODE];
    assign o_pin_irq = q.irq;
    assign o_shared_irq = q.sirq;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    sequence s_wr_port0;
        i_avs_write && !o_avs_waitrequest && idx == GPP_IDX_PORT[0] && i_avs_byteenable[0];
    endsequence

    sequence s_rd_port4;
        i_avs_read && o_avs_waitrequest && idx == GPP_IDX_PORT[4];
    endsequence

    chk_write_drive: assert property ((s_wr_port0 and (q.cfg[7][GPP_CFG_OE] && !q.cfg[7][GPP_CFG_OD]))
        ##1 (q.cfg[7][GPP_CFG_OE] && !q.cfg[7][GPP_CFG_OD])
        |=> o_pin_oe[7] && o_pin_out[7] == $past(i_avs_writedata[7], 2)) // RQ1
        else $error("port data write not driven");

    chk_read_pins: assert property (i_avs_read && o_avs_waitrequest && idx == GPP_IDX_PORT[3]
        |=> !o_avs_waitrequest && o_avs_readdata[7:0] == $past(pin_s[31:24])) // RQ2
        else $error("port read not pin level");

    chk_port4_zero: assert property (s_rd_port4 |=> o_avs_readdata[31:4] == 28'h000_0000) // RQ22
        else $error("reserved port bits not zero");

    chk_irq_gated: assert property (o_pin_irq[3] |-> $past(q.cfg[3][GPP_CFG_INT_EN], 1)) // RQ5
        else $error("interrupt from disabled pin");

    chk_irq_edge: assert property ($rose(q.hit[5]) |-> o_pin_irq[5] ##1 !o_pin_irq[5]) // RQ4
        else $error("edge interrupt not a single pulse");

    chk_shared_rearm: assert property (q.grp[0] && $past(q.grp[0]) |-> !o_shared_irq[0]) // RQ4
        else $error("shared interrupt while group active");

    chk_od_low: assert property ($past(q.cfg[24][GPP_CFG_OD]) && o_pin_oe[24] |-> !o_pin_out[24]) // RQ10
        else $error("open drain drove high");

    chk_xtal_off: assert property ($past(q.ctrl[GPP_CTL_XTAL]) |-> !o_pin_oe[0] && !o_pin_oe[1]) // RQ14
        else $error("oscillator pin driven");

    chk_spi_own: assert property ($past(spi_use[0]) |-> o_pin_oe[11] == $past(i_spi_oe[0])) // RQ16
        else $error("serial pin enable not passed");

    chk_reg_pin: assert property ($past(q.ctrl[GPP_CTL_REG_SEL])
        |-> !o_pin_oe[10] && $past(o_regulator_pin_drive)) // RQ18
        else $error("regulator pin driven as gpio");

    chk_usb_force: assert property ($past(q.ctrl[GPP_CTL_USB_MODE] && q.ctrl[GPP_CTL_USB_FORCE])
        |-> o_pin_oe[9:8] == 2'b11 && o_pin_out[9:8] == $past(q.dat[9:8])) // RQ20
        else $error("usb force not from data");

    chk_bus_wait: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
        |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
        else $error("bus answer not one cycle");

    sequence s_wr_cfg20;
        i_avs_write && !o_avs_waitrequest && idx == 6'(GPP_IDX_CFG0 + 6'h14) && i_avs_byteenable[0];
    endsequence

    sequence s_wr_ctrl;
        i_avs_write && !o_avs_waitrequest && idx == GPP_IDX_CTRL && i_avs_byteenable[0] && i_avs_byteenable[1];
    endsequence

    sequence s_out3_steady;
        q.oe[3] && $past(q.oe[3]) && q.cfg[3][GPP_CFG_INT_EN] && $stable(q.cfg[3]);
    endsequence

    chk_cfg_ttl: assert property (s_wr_cfg20 |=> o_pin_ttl[20] == $past(i_avs_writedata[GPP_CFG_TTL])) // RQ8
        else $error("threshold select not from config");

    chk_cfg_sink: assert property (s_wr_cfg20 // RQ9
        |=> o_pin_high_sink[20] == $past(i_avs_writedata[GPP_CFG_SINK]))
        else $error("sink select not from config");

    chk_cfg_pullup: assert property (s_wr_cfg20 // RQ12
        |=> o_pin_pullup[20] == $past(i_avs_writedata[GPP_CFG_PULLUP]))
        else $error("pull-up select not from config");

    chk_low_rail: assert property (s_wr_ctrl // RQ17
        |=> o_low_rail_drive == {GPP_SPI_N{$past(i_avs_writedata[GPP_CTL_LOW_RAIL])}}
        && o_regulator_on == $past(i_avs_writedata[GPP_CTL_REG_ON]))
        else $error("low rail drive wrong");

    chk_push_pull: assert property ($past(q.cfg[24][GPP_CFG_OE] && !q.cfg[24][GPP_CFG_OD]) // RQ11
        |-> o_pin_oe[24] && o_pin_out[24] == $past(q.dat[24]))
        else $error("push-pull pin not driven from data");

    chk_od_float: assert property ($past(q.cfg[24][GPP_CFG_OD] && q.dat[24]) |-> !o_pin_oe[24]) // RQ10
        else $error("open drain drove a one");

    chk_oe_off: assert property ($past(!q.cfg[24][GPP_CFG_OE]) |-> !o_pin_oe[24]) // RQ13
        else $error("driver on with enable clear");

    chk_rise_irq: assert property (s_out3_steady and ($rose(q.out[3]) && !q.cfg[3][GPP_CFG_ACT_LOW]) // RQ6 RQ7
        |=> o_pin_irq[3])
        else $error("rising edge gave no interrupt");

    chk_fall_irq: assert property (s_out3_steady and ($fell(q.out[3]) && q.cfg[3][GPP_CFG_ACT_LOW]) // RQ7
        |=> o_pin_irq[3])
        else $error("falling edge gave no interrupt");

    chk_input_irq: assert property (!q.oe[5] && !$past(q.oe[5]) && $rose(pin_s[5]) && $stable(q.cfg[5]) // RQ3
        && q.cfg[5][GPP_CFG_INT_EN] && !q.cfg[5][GPP_CFG_ACT_LOW] |=> o_pin_irq[5])
        else $error("input edge gave no interrupt");

    chk_shared_raise: assert property (!q.grp[0] && |hit_v[23:16] |=> o_shared_irq[0]) // RQ4
        else $error("shared interrupt not raised");

    chk_irq_off: assert property (!q.cfg[3][GPP_CFG_INT_EN] |=> !o_pin_irq[3]) // RQ5
        else $error("interrupt raised while disabled");

    chk_usb_lines: assert property ($past(q.ctrl[GPP_CTL_USB_MODE] && !q.ctrl[GPP_CTL_USB_FORCE]) // RQ19
        |-> o_pin_oe[9:8] == {2{$past(i_usb_oe)}} && o_pin_out[9:8] == $past(i_usb_out))
        else $error("usb lines not from transceiver");

    chk_usb_gpio: assert property ($past(!q.ctrl[GPP_CTL_USB_MODE] && q.cfg[8][GPP_CFG_OE]) // RQ19
        && $past(!q.cfg[8][GPP_CFG_OD]) |-> o_pin_oe[8] && o_pin_out[8] == $past(q.dat[8]))
        else $error("usb pin not plain gpio");

    chk_spi_gpio: assert property ($past(!spi_use[0] && q.cfg[11][GPP_CFG_OE]) // RQ15
        && $past(!q.cfg[11][GPP_CFG_OD]) |-> o_pin_oe[11] && o_pin_out[11] == $past(q.dat[11]))
        else $error("serial pin not plain gpio");

    chk_reg_gpio: assert property ($past(!q.ctrl[GPP_CTL_REG_SEL] && q.cfg[10][GPP_CFG_OE]) // RQ15
        && $past(!q.cfg[10][GPP_CFG_OD]) |-> o_pin_oe[10])
        else $error("regulator pin enable ignored");

    chk_port4_mask: assert property (i_avs_write && !o_avs_waitrequest && idx == GPP_IDX_PORT[4] // RQ22
        |=> q.dat[39:36] == 4'h0)
        else $error("reserved port bits written");
endmodule : gpp_gpio_port

// file: verification/gpp_pin_model.sv
`timescale 1ns/1ps
// ------
// external circuitry on the pins
// ------
module gpp_pin_model (
    input wire logic i_clk,
    input wire logic [39:0] i_out,
    input wire logic [39:0] i_oe,
    input wire logic [39:0] i_pu,
    input wire logic [39:0] i_ext_en,
    input wire logic [39:0] i_ext,
    output logic [39:0] o_pin
);
    logic [39:0] flt_q = 40'h00_0000_0000;
    // a pin nobody drives or pulls up wanders every cycle
    always @(posedge i_clk) begin
        flt_q <= ~flt_q;
    end
    always_comb begin
        for (int i = 0; i < 40; i++) begin
            o_pin[i] = i_oe[i] ? i_out[i] : i_ext_en[i] ? i_ext[i] : i_pu[i] ? 1'b1 : flt_q[i];
        end
    end
endmodule : gpp_pin_model

// file: verification/gpp_gpio_port_test.sv
`timescale 1ns/1ps
module gpp_gpio_port_test;
    import gpp_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic usb_oe = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] be = 4'hf;
    logic [3:0] spi_oe = 4'h0;
    logic [3:0] spi_out = 4'h0;
    logic [1:0] usb_out = 2'h0;
    logic [31:0] wd = 32'h0000_0000;
    logic [39:0] ext = 40'h00_0000_0000;
    logic [39:0] ext_en = 40'hff_ffff_ffff;
    logic [31:0] rdat;
    logic [39:0] pin, pout, poe, pttl, psink, ppu;
    logic [15:0] pirq;
    logic [2:0] sirq;
    logic [3:0] lrd;
    logic wrq, xo, rpd, ron, usbm;
    logic [18:0] irqs;
    logic [7:0] dat_m [5];
    logic [6:0] cfg_m [40];
    int hits [19] = '{default: 0};
    int xh [19] = '{default: 0};
    int mismatches = 0;
    int compares = 0;
    int seed = 41410;
    assign irqs = {sirq, pirq};
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        for (int k = 0; k < 19; k++) begin
            hits[k] <= hits[k] + int'(irqs[k]);
        end
    end
    gpp_gpio_port gpp_gpio_port_inst (
        .i_clk(clk), .i_rst_n(rst_n), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rdat), .o_avs_waitrequest(wrq),
        .i_pin(pin), .o_pin_out(pout), .o_pin_oe(poe), .o_pin_ttl(pttl), .o_pin_high_sink(psink),
        .o_pin_pullup(ppu), .i_spi_oe(spi_oe), .i_spi_out(spi_out), .i_usb_oe(usb_oe), .i_usb_out(usb_out),
        .o_low_rail_drive(lrd), .o_crystal_osc_on(xo), .o_regulator_pin_drive(rpd), .o_regulator_on(ron),
        .o_usb_mode(usbm), .o_pin_irq(pirq), .o_shared_irq(sirq));
    gpp_pin_model gpp_pin_model_inst (
        .i_clk(clk), .i_out(pout), .i_oe(poe), .i_pu(ppu), .i_ext_en(ext_en), .i_ext(ext), .o_pin(pin));
    // ------
    // tasks
    // ------
    task automatic complete_run;
        if (mismatches == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [5:0] idx, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        adr <= {idx, 2'b00};
        wr <= w;
        rd <= ~w;
        wd <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wrq !== 1'b0 && n < 50);
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
        if (n >= 50) begin
            mismatches++;
            complete_run();
        end
    endtask : bus
    task automatic wreg(input logic [5:0] idx, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, idx, d, q);
        if (idx < 6'h05) dat_m[idx] = (idx == 6'h04) ? d[7:0] & 8'h0f : d[7:0];
        else if (idx < 6'h29) cfg_m[idx - 6'h05] = d[6:0];
        repeat (3) @(posedge clk);
    endtask : wreg
    task automatic rchk(input logic [5:0] idx, input logic [7:0] e);
        logic [31:0] q;
        bus(1'b0, idx, 32'h0000_0000, q);
        chk("readdata", {32'h0000_0000, e}, {8'h00, q});
    endtask : rchk
    task automatic dw(input int p, input int n, input logic v);
        logic [7:0] d;
        d = dat_m[p];
        d[n] = v;
        wreg(6'(p), {24'h00_0000, d});
    endtask : dw
    task automatic setx(input int i, input logic v);
        @(posedge clk);
        ext[i] <= v;
        ext_en[i] <= 1'b1;
    endtask : setx
    task automatic ev(input int k, input int e);
        repeat (8) @(posedge clk);
        xh[k] += e;
        chk("irq count", 40'(xh[k]), 40'(hits[k]));
    endtask : ev
    function automatic logic [7:0] exp_port(input int p);
        logic [7:0] v;
        logic [6:0] c;
        int i;
        v = 8'h00;
        for (int n = 0; n < 8; n++) begin
            i = 8 * p + n;
            c = cfg_m[i];
            if (i >= 36) v[n] = 1'b0;
            else if (c[GPP_CFG_OE] && !(c[GPP_CFG_OD] && dat_m[p][n])) v[n] = dat_m[p][n] & ~c[GPP_CFG_OD];
            else v[n] = ext_en[i] ? ext[i] : c[GPP_CFG_PULLUP];
        end
        return v;
    endfunction : exp_port
    task automatic pins;
        logic [39:0] oe_e, out_e, t_e, s_e, u_e;
        for (int i = 0; i < 40; i++) begin
            t_e[i] = cfg_m[i][GPP_CFG_TTL];
            s_e[i] = cfg_m[i][GPP_CFG_SINK];
            u_e[i] = cfg_m[i][GPP_CFG_PULLUP];
            out_e[i] = dat_m[i / 8][i % 8] & ~cfg_m[i][GPP_CFG_OD];
            oe_e[i] = cfg_m[i][GPP_CFG_OE] & ~(cfg_m[i][GPP_CFG_OD] & dat_m[i / 8][i % 8]);
        end
        chk("pin oe", oe_e, poe);
        chk("pin out", out_e & oe_e, pout & oe_e);
        chk("pin ttl", t_e, pttl);
        chk("pin sink", s_e, psink);
        chk("pin pullup", u_e, ppu);
    endtask : pins
    // ------
    // scenarios
    // ------
    initial begin
        for (int i = 0; i < 40; i++) cfg_m[i] = 7'h00;
        for (int p = 0; p < 5; p++) dat_m[p] = 8'h00;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        pins();
        for (int p = 0; p < 5; p++) rchk(6'(p), exp_port(p));
        repeat (2) begin
            for (int i = 0; i < 36; i++) wreg(6'(5 + i), $random(seed) & 32'h0000_001f);
            for (int i = 0; i < 40; i++) ext_en[i] <= ~cfg_m[i][GPP_CFG_PULLUP];
            ext <= 40'({$random(seed), $random(seed)});
            for (int p = 0; p < 5; p++) wreg(6'(p), $random(seed));
            pins();
            for (int p = 0; p < 5; p++) rchk(6'(p), exp_port(p));
        end
        rchk(6'h29, 8'h00);
        rchk(6'h19, {1'b0, cfg_m[20]});
        wreg(6'h3f, 32'hffff_ffff);
        rchk(6'h3f, 8'h00);
        // interrupts from a driven pin
        setx(3, 1'b0);
        wreg(6'h08, 32'h0000_0000);
        dw(0, 3, 1'b0);
        wreg(6'h08, 32'h0000_0041);
        ev(3, 0);
        dw(0, 3, 1'b1);
        ev(3, 1);
        dw(0, 3, 1'b0);
        ev(3, 0);
        wreg(6'h08, 32'h0000_0001);
        dw(0, 3, 1'b1);
        wreg(6'h08, 32'h0000_0021);
        wreg(6'h08, 32'h0000_0061);
        ev(3, 0);
        dw(0, 3, 1'b0);
        ev(3, 1);
        // interrupts from input pins
        wreg(6'h0a, 32'h0000_0000);
        wreg(6'h15, 32'h0000_0000);
        wreg(6'h16, 32'h0000_0000);
        setx(5, 1'b0);
        setx(16, 1'b0);
        setx(17, 1'b0);
        repeat (6) @(posedge clk);
        wreg(6'h0a, 32'h0000_0040);
        wreg(6'h15, 32'h0000_0040);
        wreg(6'h16, 32'h0000_0040);
        setx(5, 1'b1);
        ev(5, 1);
        setx(16, 1'b1);
        ev(16, 1);
        setx(17, 1'b1);
        ev(16, 0);
        setx(16, 1'b0);
        ev(16, 0);
        setx(17, 1'b0);
        setx(17, 1'b1);
        ev(16, 1);
        // shared-function pins
        foreach (cfg_m[i]) if (i < 2 || (i > 7 && i < 11)) wreg(6'(5 + i), 32'h0000_0001);
        dw(0, 0, 1'b1);
        dw(0, 1, 1'b1);
        wreg(GPP_IDX_CTRL, 32'h0000_0001);
        chk("crystal", 40'h00_0000_0001, {37'h0, poe[1:0], xo});
        wreg(GPP_IDX_CTRL, 32'h0000_0008);
        chk("low rail", 40'h00_0000_001e, {35'h0, lrd, ron});
        wreg(GPP_IDX_CTRL, 32'h0000_0006);
        chk("regulator", 40'h00_0000_0003, {37'h0, poe[10], rpd, ron});
        spi_oe <= 4'($random(seed));
        spi_out <= 4'($random(seed));
        wreg(GPP_IDX_CTRL, 32'h0000_03c0);
        chk("serial oe", {36'h0, spi_oe}, {36'h0, poe[14:11]});
        chk("serial out", {36'h0, spi_out & spi_oe}, {36'h0, pout[14:11] & spi_oe});
        usb_oe <= 1'b1;
        usb_out <= 2'b10;
        wreg(GPP_IDX_CTRL, 32'h0000_0010);
        chk("usb lines", 40'h00_0000_001d, {35'h0, poe[9:8], pout[9:8], usbm});
        usb_oe <= 1'b0;
        dw(1, 0, 1'b1);
        dw(1, 1, 1'b0);
        wreg(GPP_IDX_CTRL, 32'h0000_0030);
        chk("usb force", 40'h00_0000_001b, {35'h0, poe[9:8], pout[9:8], usbm});
        wreg(GPP_IDX_CTRL, 32'h0000_0000);
        wreg(6'h1d, 32'h0000_0005);
        dw(3, 0, 1'b0);
        pins();
        dw(3, 0, 1'b1);
        pins();
        for (int k = 0; k < 19; k++) chk("irq total", 40'(xh[k]), 40'(hits[k]));
        complete_run();
    end
endmodule : gpp_gpio_port_test
